// ### rx_serial_toh_port.sv
// receive overhead capture, serial overhead ports and parallel overhead rebuild
`timescale 1ns/1ps
`default_nettype none
`include "rxtoh_map.svh"

module rx_serial_toh_port (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic overhead_clock,
   input wire rxtoh_pkg::rxtoh_line_t lineIn,
   input wire logic speStart,
   output logic inReady,
   input wire logic [`RXTOH_CHANNELS-1:0] lossOfFrame,
   input wire logic [`RXTOH_CHANNELS-1:0] forceLineAis,
   input wire logic moverActive,
   input wire logic transportMode,
   input wire logic apsPassEnable,
   input wire rxtoh_pkg::rxtoh_par_in_t parIn,
   output rxtoh_pkg::rxtoh_par_out_t parOut,
   output logic rx_overhead_row_pulse,
   output logic rx_overhead_clock_enable,
   output logic [`RXTOH_CHANNELS-1:0] serialData
);

   rxtoh_pkg::rxtoh_state_t st_q;
   rxtoh_pkg::rxtoh_state_t st_d;

   // rebuild of one overhead byte for the parallel output bus
   function automatic logic [7:0] rebuildByte(input rxtoh_pkg::rxtoh_par_in_t p,
                                              input logic mover,
                                              input logic transport,
                                              input logic apsPass);
      logic [7:0] b;
      b = 8'h00;
      if (!mover) begin
         b = p.data;
      end else if (p.row == `RXTOH_ROW_FRAMING && p.col < `RXTOH_COL_H3_FIRST) begin
         b = (p.col < `RXTOH_COL_A2_FIRST) ? `RXTOH_A1_VALUE : `RXTOH_A2_VALUE;
      end else if (p.row == `RXTOH_ROW_POINTER) begin
         if (p.col >= `RXTOH_COL_H3_FIRST) begin
            b = p.negStuff ? p.storeByte : 8'h00;
         end else if (p.pathAis) begin
            b = `RXTOH_ALL_ONES;
         end else begin
            // ss bits stay as received, the rest follows the pointer generator
            if (p.col < `RXTOH_COL_A2_FIRST) begin
               b = p.ptrGen1;
               b[`RXTOH_SS_HI:`RXTOH_SS_LO] = p.data[`RXTOH_SS_HI:`RXTOH_SS_LO];
            end else begin
               b = p.ptrGen2;
            end
         end
      end else if (p.row == `RXTOH_ROW_APS &&
                   (p.col == `RXTOH_COL_K1 || p.col == `RXTOH_COL_K2)) begin
         if (transport && p.lineAis) begin
            b = `RXTOH_ALL_ONES;
         end else begin
            b = apsPass ? p.data : 8'h00;
         end
      end else begin
         b = 8'h00;
      end
      return b;
   endfunction

   // one copy of the whole state is filled here and registered below; the overhead
   // clock is only ever seen as a sampled level, so all its outputs move on sys_clk
   always_comb begin
      logic ckRise;
      logic push;
      logic pop;
      logic [`RXTOH_CHANNELS-1:0] ais;
      rxtoh_pkg::rxtoh_entry_t head;
      ckRise = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      ais = '0;
      head = '0;
      st_d = st_q;

      // overhead clock is sampled like any foreign pin; only stage two is read
      st_d.ckSync = {st_q.ckSync[0], overhead_clock};
      st_d.ckPrev = st_q.ckSync[1];
      // the edge is seen late, so every launch trails the pin rise by three sys_clk edges
      ckRise = st_q.ckSync[1] & ~st_q.ckPrev;

      // capture side, sys_clk
      // a row is complete after 36 valid bytes; bytes with no row open are dropped
      if (lineIn.valid) begin
         if (lineIn.rowStart) begin
            st_d.capCount = 6'h01;
            st_d.capFirst = lineIn.frameStart;
            st_d.rowDone = 1'b0;
         end else if (st_q.capCount != 6'h00 && !st_q.rowDone) begin
            st_d.capCount = st_q.capCount + 6'h01;
         end
         if (lineIn.rowStart || (st_q.capCount != 6'h00 && !st_q.rowDone)) begin
            for (int c = 0; c < `RXTOH_CHANNELS; c++) begin
               st_d.capRow[c] = {st_q.capRow[c][`RXTOH_ROW_BITS-9:0], lineIn.bytes[c]};
            end
            if (!lineIn.rowStart && st_q.capCount == `RXTOH_ROW_LAST_BYTE) begin
               st_d.rowDone = 1'b1;
            end
         end
      end

      // a full buffer refuses the row; inReady tells the source to hold off
      if (speStart && st_q.rowDone && st_q.fifoCount != 2'h2) begin
         push = 1'b1;
         st_d.fifo[st_q.wrPtr].first = st_q.capFirst;
         st_d.fifo[st_q.wrPtr].bits = st_q.capRow;
         st_d.wrPtr = ~st_q.wrPtr;
         st_d.rowDone = 1'b0;
         st_d.capCount = 6'h00;
      end

      // serial side, one bit per overhead clock rise
      // ais is taken live, so a cause rising mid-row forces only the rest of that row
      ais = lossOfFrame | forceLineAis;
      // two entries only: single-bit pointers, fifoCount tells full from empty
      head = st_q.fifo[st_q.rdPtr];
      if (ckRise) begin
         st_d.rowPulse = 1'b0;
         if (st_q.shifting) begin
            for (int c = 0; c < `RXTOH_CHANNELS; c++) begin
               st_d.serialData[c] = ais[c] | st_q.txRow[c][`RXTOH_ROW_BITS-1];
               st_d.txRow[c] = {st_q.txRow[c][`RXTOH_ROW_BITS-2:0], 1'b0};
            end
            st_d.clockEnable = 1'b1;
            // bitCnt counts bits already launched, so the last bit meets 287
            if (st_q.bitCnt == `RXTOH_LAST_BIT) begin
               st_d.shifting = 1'b0;
               st_d.txFirst = 1'b0;
            end
            st_d.bitCnt = st_q.bitCnt + 9'h001;
         end else if (st_q.fifoCount != 2'h0) begin
            pop = 1'b1;
            st_d.rdPtr = ~st_q.rdPtr;
            st_d.shifting = 1'b1;
            st_d.bitCnt = 9'h001;
            st_d.txFirst = head.first;
            st_d.rowPulse = 1'b1;
            st_d.clockEnable = 1'b1;
            // parity uses raw bits, so line AIS cannot disturb the next frame's parity
            for (int c = 0; c < `RXTOH_CHANNELS; c++) begin
               if (head.first) begin
                  st_d.parHold[c] = st_q.parAccum[c];
                  st_d.parAccum[c] = ^head.bits[c];
               end else begin
                  st_d.parAccum[c] = st_q.parAccum[c] ^ (^head.bits[c]);
               end
            end
            for (int c = 0; c < `RXTOH_CHANNELS; c++) begin
               st_d.txRow[c] = {head.bits[c][`RXTOH_ROW_BITS-2:0], 1'b0};
               if (head.first) begin
                  st_d.serialData[c] = ais[c] | st_q.parAccum[c];
               end else begin
                  st_d.serialData[c] = ais[c] | head.bits[c][`RXTOH_ROW_BITS-1];
               end
            end
         end else begin
            st_d.clockEnable = 1'b0;
            st_d.serialData = '0;
         end
      end

      case ({push, pop})
         2'b10: st_d.fifoCount = st_q.fifoCount + 2'h1;
         2'b01: st_d.fifoCount = st_q.fifoCount - 2'h1;
         2'b11: st_d.fifoCount = st_q.fifoCount;
         2'b00: st_d.fifoCount = st_q.fifoCount;
         default: st_d.fifoCount = st_q.fifoCount;
      endcase
      // taken from the next count so the source sees full right after the push
      st_d.inReady = (st_d.fifoCount != 2'h2);

      // bytes of the parallel bus are rebuilt one cycle behind the input
      st_d.parOut.valid = parIn.valid;
      if (parIn.valid) begin
         st_d.parOut.data = rebuildByte(parIn, moverActive, transportMode, apsPassEnable);
      end else begin
         st_d.parOut.data = 8'h00;
      end
   end

   // state is cleared as one word; every output reads straight from st_q
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign inReady = st_q.inReady;
   assign parOut = st_q.parOut;
   assign rx_overhead_row_pulse = st_q.rowPulse;
   assign rx_overhead_clock_enable = st_q.clockEnable;
   assign serialData = st_q.serialData;

endmodule
`default_nettype wire

// ### rx_serial_toh_port_tb.sv
// testbench of the receive overhead serial port
`timescale 1ns/1ps
`default_nettype none
`include "rxtoh_map.svh"
module rx_serial_toh_port_tb;
   typedef logic [`RXTOH_CHANNELS-1:0][`RXTOH_ROW_BITS-1:0] rxtoh_rows_t;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic speStart = 1'b0;
   logic moverActive = 1'b0;
   logic transportMode = 1'b0;
   logic apsPassEnable = 1'b0;
   logic [`RXTOH_CHANNELS-1:0] lossOfFrame = '0;
   logic [`RXTOH_CHANNELS-1:0] forceLineAis = '0;
   rxtoh_pkg::rxtoh_line_t lineIn = '0;
   rxtoh_pkg::rxtoh_par_in_t parIn = '0;
   rxtoh_pkg::rxtoh_par_out_t parOut;
   wire overhead_clock;
   logic inReady, rx_overhead_row_pulse, rx_overhead_clock_enable;
   logic [`RXTOH_CHANNELS-1:0] serialData;
   logic [`RXTOH_CHANNELS-1:0] parAcc = '0;
   integer seed = 95648;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;
   rxtoh_rows_t expQ[$];
   rx_serial_toh_port u_dut (.sys_clk, .resetn, .overhead_clock, .lineIn, .speStart, .inReady,
      .lossOfFrame, .forceLineAis, .moverActive, .transportMode, .apsPassEnable, .parIn,
      .parOut, .rx_overhead_row_pulse, .rx_overhead_clock_enable, .serialData);
   rxtoh_fabric_model u_fab (.overhead_clock, .rx_overhead_row_pulse,
      .rx_overhead_clock_enable, .serialData);
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [287:0] exp, input logic [287:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // parity of a frame row covers all bits from the previous frame row up to the row before it
   function automatic rxtoh_rows_t expRow(rxtoh_rows_t r, bit frame, logic [7:0] ais);
      rxtoh_rows_t e = r;
      for (int c = 0; c < `RXTOH_CHANNELS; c++) begin
         if (frame) e[c][`RXTOH_ROW_BITS-1] = parAcc[c];
         parAcc[c] = frame ? ^r[c] : parAcc[c] ^ (^r[c]);
         if (ais[c]) e[c] = '1;
      end
      return e;
   endfunction
   task automatic loadRow(input bit frame, input logic [7:0] ais);
      rxtoh_rows_t r;
      logic [`RXTOH_CHANNELS-1:0][7:0] by;
      for (int b = 0; b < `RXTOH_ROW_BYTES; b++) begin
         for (int c = 0; c < `RXTOH_CHANNELS; c++) begin
            by[c] = 8'($random(seed));
            r[c][`RXTOH_ROW_BITS-1-8*b -: 8] = by[c];
         end
         @(posedge sys_clk);
         lineIn <= {1'b1, b == 0, frame && b == 0, by};
      end
      @(posedge sys_clk);
      lineIn.valid <= 1'b0;
      expQ.push_back(expRow(r, frame, ais));
   endtask
   task automatic pulseStart();
      @(posedge sys_clk);
      speStart <= 1'b1;
      @(posedge sys_clk);
      speStart <= 1'b0;
   endtask
   task automatic pushRow();
      @(negedge sys_clk);
      while (inReady !== 1'b1) @(negedge sys_clk);
      pulseStart();
   endtask
   task automatic waitRows(input int n);
      while (u_fab.rows.size() < n) @(posedge sys_clk);
   endtask
   // random parallel traffic runs beside the serial rows
   always @(posedge sys_clk) begin
      rxtoh_pkg::rxtoh_par_in_t p;
      cycles++;
      if (cycles > 60000) begin
         fail_count++;
         print_verdict();
      end
      if (resetn) begin
         p = 46'({$random(seed), $random(seed)});
         p.row = 4'($unsigned($random(seed)) % 9);
         p.col = 6'($unsigned($random(seed)) % 36);
         parIn <= p;
         moverActive <= (2'($random(seed)) != 2'h0);
         transportMode <= 1'($random(seed));
         apsPassEnable <= 1'($random(seed));
      end
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check("ready", 1, inReady);
      loadRow(1, 8'h00);
      pushRow();
      loadRow(0, 8'h00);
      pushRow();
      loadRow(0, 8'h00);
      pushRow();
      @(negedge sys_clk);
      check("full", 0, inReady);
      loadRow(1, 8'h00);
      pulseStart();
      pushRow();
      loadRow(0, 8'h00);
      pushRow();
      waitRows(5);
      lossOfFrame <= 8'h20;
      forceLineAis <= 8'h04;
      loadRow(0, 8'h24);
      pushRow();
      waitRows(6);
      lossOfFrame <= 8'h00;
      forceLineAis <= 8'h00;
      loadRow(1, 8'h00);
      pushRow();
      waitRows(7);
      check("rows", 7, u_fab.rows.size());
      check("framing", 0, u_fab.frameErrs);
      foreach (expQ[i]) begin
         for (int c = 0; c < `RXTOH_CHANNELS; c++) begin
            check("row bits", expQ[i][c], u_fab.rows[i][c]);
         end
      end
      print_verdict();
   end
endmodule
`default_nettype wire

// ### rxtoh_fabric_model.sv
// fabric-side model: makes the overhead clock and collects serial rows
`timescale 1ns/1ps
`default_nettype none
`include "rxtoh_map.svh"
module rxtoh_fabric_model (
   output logic overhead_clock,
   input wire logic rx_overhead_row_pulse,
   input wire logic rx_overhead_clock_enable,
   input wire logic [`RXTOH_CHANNELS-1:0] serialData
);
   typedef logic [`RXTOH_CHANNELS-1:0][`RXTOH_ROW_BITS-1:0] rxtoh_row_t;
   rxtoh_row_t rows[$];
   rxtoh_row_t cur;
   int cnt = 0;
   int frameErrs = 0;
   // free running; phase kept off the system clock edges
   initial begin
      overhead_clock = 1'b0;
      #3;
      forever #80 overhead_clock = ~overhead_clock;
   end
   always @(posedge overhead_clock) begin
      if (rx_overhead_clock_enable === 1'b1) begin
         if (rx_overhead_row_pulse !== (cnt == 0)) frameErrs++;
         for (int c = 0; c < `RXTOH_CHANNELS; c++) begin
            cur[c] = {cur[c][`RXTOH_ROW_BITS-2:0], serialData[c]};
         end
         cnt++;
         if (cnt == `RXTOH_ROW_BITS) begin
            rows.push_back(cur);
            cnt = 0;
         end
      end
   end
endmodule
`default_nettype wire

// ### rxtoh_map.svh
// constants of the receive overhead serial port
`ifndef RXTOH_MAP_SVH
`define RXTOH_MAP_SVH
`define RXTOH_CHANNELS 8
`define RXTOH_ROW_BYTES 36
`define RXTOH_ROW_BITS 288
`define RXTOH_LAST_BIT 9'h11F
`define RXTOH_ROW_LAST_BYTE 6'h23
`define RXTOH_A1_VALUE 8'hF6
`define RXTOH_A2_VALUE 8'h28
`define RXTOH_ALL_ONES 8'hFF
`define RXTOH_ROW_FRAMING 4'h0
`define RXTOH_ROW_POINTER 4'h3
`define RXTOH_ROW_APS 4'h4
`define RXTOH_COL_A2_FIRST 6'h0C
`define RXTOH_COL_H3_FIRST 6'h18
`define RXTOH_COL_K1 6'h0C
`define RXTOH_COL_K2 6'h18
`define RXTOH_SS_HI 3
`define RXTOH_SS_LO 2
`endif

// ### rxtoh_monitor.sv
// assertions on the receive overhead port
`timescale 1ns/1ps
`default_nettype none
`include "rxtoh_map.svh"
module rxtoh_monitor (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic overhead_clock,
   input wire logic inReady,
   input wire logic moverActive,
   input wire logic transportMode,
   input wire logic apsPassEnable,
   input wire rxtoh_pkg::rxtoh_par_in_t parIn,
   input wire rxtoh_pkg::rxtoh_par_out_t parOut,
   input wire logic rx_overhead_row_pulse,
   input wire logic rx_overhead_clock_enable,
   input wire logic [`RXTOH_CHANNELS-1:0] serialData
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic pv;
   logic kAt;
   assign pv = parIn.valid && moverActive;
   assign kAt = parIn.row == `RXTOH_ROW_APS && parIn.col == `RXTOH_COL_K1;
   a_pulse_in_burst: assert property (
      rx_overhead_row_pulse |-> rx_overhead_clock_enable) else $error("pulse outside burst");
   a_pulse_one_period: assert property (
      $rose(rx_overhead_row_pulse) |-> ##20 !rx_overhead_row_pulse) else $error("long pulse");
   // sync of two flops plus edge detect puts every launch three edges late
   a_launch_on_rise: assert property (
      $changed({rx_overhead_row_pulse, rx_overhead_clock_enable, serialData})
      |-> $past(overhead_clock, 3) && !$past(overhead_clock, 4)) else $error("launch off edge");
   a_ready_after_reset: assert property (
      $rose(resetn) |=> inReady) else $error("not ready after reset");
   a_pass_when_off: assert property (
      parIn.valid && !moverActive |=> parOut.valid && parOut.data == $past(parIn.data))
      else $error("bypass altered byte");
   a_a1_regen: assert property (
      pv && parIn.row == `RXTOH_ROW_FRAMING && parIn.col < `RXTOH_COL_A2_FIRST
      |=> parOut.data == `RXTOH_A1_VALUE) else $error("framing byte wrong");
   a_h3_byte: assert property (
      pv && !parIn.pathAis && parIn.row == `RXTOH_ROW_POINTER && parIn.col >= `RXTOH_COL_H3_FIRST
      |=> parOut.data == ($past(parIn.negStuff) ? $past(parIn.storeByte) : 8'h00))
      else $error("stuff byte wrong");
   a_zero_rows: assert property (
      pv && parIn.row == 4'h1 |=> parOut.data == 8'h00) else $error("unused byte not zero");
   a_k_zeroed: assert property (
      pv && kAt && !apsPassEnable && !transportMode |=> parOut.data == 8'h00)
      else $error("protection byte not zeroed");
   a_k_passed: assert property (
      pv && kAt && apsPassEnable && !transportMode |=> parOut.data == $past(parIn.data))
      else $error("protection byte not passed");
   a_k_line_ais: assert property (
      pv && kAt && transportMode && parIn.lineAis |=> parOut.data == `RXTOH_ALL_ONES)
      else $error("line ais missing on protection byte");
   a_h1_ss_kept: assert property (
      pv && !parIn.pathAis && parIn.row == `RXTOH_ROW_POINTER && parIn.col < `RXTOH_COL_A2_FIRST
      |=> parOut.data[`RXTOH_SS_HI:`RXTOH_SS_LO] ==
          $past(parIn.data[`RXTOH_SS_HI:`RXTOH_SS_LO])) else $error("ss bits altered");
   a_path_ais: assert property (
      pv && parIn.pathAis && parIn.row == `RXTOH_ROW_POINTER && parIn.col < `RXTOH_COL_H3_FIRST
      |=> parOut.data == `RXTOH_ALL_ONES) else $error("path ais not all ones");
   cover property ($rose(rx_overhead_row_pulse));
   cover property ($fell(inReady));
   cover property (pv && kAt && apsPassEnable);
endmodule
bind rx_serial_toh_port rxtoh_monitor u_mon (.sys_clk, .resetn, .overhead_clock, .inReady,
   .moverActive, .transportMode, .apsPassEnable, .parIn, .parOut, .rx_overhead_row_pulse,
   .rx_overhead_clock_enable, .serialData);
`default_nettype wire

// ### rxtoh_pkg.sv
// types of the receive overhead serial port
`include "rxtoh_map.svh"
package rxtoh_pkg;
   // one received overhead byte for each channel
   typedef struct packed {
      logic valid;
      logic rowStart;
      logic frameStart;
      logic [`RXTOH_CHANNELS-1:0][7:0] bytes;
   } rxtoh_line_t;
   // one captured row: per channel, first received bit in the msb
   typedef struct packed {
      logic first;
      logic [`RXTOH_CHANNELS-1:0][`RXTOH_ROW_BITS-1:0] bits;
   } rxtoh_entry_t;
   // one overhead byte on its way to the parallel output bus
   typedef struct packed {
      logic valid;
      logic [3:0] row;
      logic [5:0] col;
      logic [7:0] data;
      logic [7:0] ptrGen1;
      logic [7:0] ptrGen2;
      logic negStuff;
      logic [7:0] storeByte;
      logic pathAis;
      logic lineAis;
   } rxtoh_par_in_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rxtoh_par_out_t;
   typedef struct packed {
      logic [1:0] ckSync;
      logic ckPrev;
      logic [5:0] capCount;
      logic capFirst;
      logic rowDone;
      logic [`RXTOH_CHANNELS-1:0][`RXTOH_ROW_BITS-1:0] capRow;
      rxtoh_entry_t [1:0] fifo;
      logic [1:0] fifoCount;
      logic wrPtr;
      logic rdPtr;
      logic inReady;
      logic shifting;
      logic [8:0] bitCnt;
      logic txFirst;
      logic [`RXTOH_CHANNELS-1:0][`RXTOH_ROW_BITS-1:0] txRow;
      logic [`RXTOH_CHANNELS-1:0] parAccum;
      logic [`RXTOH_CHANNELS-1:0] parHold;
      logic rowPulse;
      logic clockEnable;
      logic [`RXTOH_CHANNELS-1:0] serialData;
      rxtoh_par_out_t parOut;
   } rxtoh_state_t;
endpackage
